// >>> viar_map.svh
`ifndef VIAR_MAP_SVH
`define VIAR_MAP_SVH
// Vector byte width and the bit that always reads as zero
`define VIAR_VEC_W          8
`define VIAR_VEC_LSB        0
// Reset values of the two vector registers
`define VIAR_VEC1_RST       8'h00
`define VIAR_VEC2_RST       8'h00
// Restart opcode handed out in restart-opcode mode (lowest restart)
`define VIAR_RST_OPCODE     8'hc7
`endif

// >>> viar_pkg.sv
// ----------------------------------------
// Types of the vectored acknowledge responder
// ----------------------------------------
package viar_pkg;
    // Acknowledge answer style
    typedef enum logic [1:0] {
        VIAR_ANS_VECTOR,
        VIAR_ANS_RESTART
    } viar_ans_e;
    // Acknowledge sequence states
    typedef enum logic [1:0] {
        VIAR_IDLE,
        VIAR_ANNOUNCED,
        VIAR_DRIVE,
        VIAR_SERVICE
    } viar_state_e;
    // Data byte type
    typedef logic [7:0] viar_byte_t;
endpackage

// >>> viar_responder.sv
// Overview of operation
// - Restart mode answers acknowledge with restart opcode.
// - Service need in chain mode asserts request.
// - Low chain enable input blocks all requests.
// - Acknowledge announces next cycle is acknowledge read.
// - Device drives one vector register on bus.
// - Vector least significant bit always reads zero.
// - Chain output high only if input high, idle.
// - Chain output stays low until clear-in-service.
// - Reset gives plain mode; command sets chain mode.
`timescale 1ns/1ns
`default_nettype none
`include "viar_map.svh"
module viar_responder (
    input  wire logic              sys_clk,
    input  wire logic              srst,
    input  wire logic              service_req,
    input  wire logic              vector_select,
    input  wire viar_pkg::viar_ans_e answer_style,
    input  wire logic              set_chain_mode_cmd,
    input  wire logic              clear_in_service_cmd,
    input  wire logic              vec_wr_one,
    input  wire logic              vec_wr_two,
    input  wire viar_pkg::viar_byte_t vec_wr_data,
    input  wire logic              ack_in_n,
    input  wire logic              chain_enable_in,
    output logic                   irq_out_n,
    output logic                   chain_enable_out,
    output logic                   chain_mode,
    output logic                   in_service,
    output viar_pkg::viar_byte_t   data_out,
    output logic                   data_oe
);
    import viar_pkg::*;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [2:0] ack_sync_r;                // Acknowledge, three stages
    logic [2:0] ack_sync_nxt;
    logic [2:0] iei_sync_r;                // Chain enable in, three stages
    logic [2:0] iei_sync_nxt;
    logic       ack_stable_r;              // Filtered acknowledge level (high = asserted)
    logic       ack_stable_nxt;
    logic       iei_stable_r;              // Filtered chain enable level
    logic       iei_stable_nxt;

    // Next values of the synchronisers
    always_comb begin
        ack_sync_nxt = {ack_sync_r[1:0], ~ack_in_n};
        iei_sync_nxt = {iei_sync_r[1:0], chain_enable_in};
        ack_stable_nxt = ack_stable_r;
        iei_stable_nxt = iei_stable_r;
        // Change counts when stages two and three agree
        if (ack_sync_r[1] == ack_sync_r[2]) begin
            ack_stable_nxt = ack_sync_r[2];
        end
        if (iei_sync_r[1] == iei_sync_r[2]) begin
            iei_stable_nxt = iei_sync_r[2];
        end
    end

    // Register the synchronisers
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ack_sync_r   <= 3'h0;
            iei_sync_r   <= 3'h0;
            ack_stable_r <= 1'b0;
            iei_stable_r <= 1'b0;
        end else begin
            ack_sync_r   <= ack_sync_nxt;
            iei_sync_r   <= iei_sync_nxt;
            ack_stable_r <= ack_stable_nxt;
            iei_stable_r <= iei_stable_nxt;
        end
    end

    // ----------------------------------------
    // Vector registers and mode
    // ----------------------------------------
    viar_byte_t  vec_one_r;                // vector_reg_one
    viar_byte_t  vec_one_nxt;
    viar_byte_t  vec_two_r;                // vector_reg_two
    viar_byte_t  vec_two_nxt;
    logic        chain_mode_r;             // Vectored chain mode active
    logic        chain_mode_nxt;
    viar_state_e state_r;                  // Acknowledge sequence
    viar_state_e state_nxt;
    logic        ack_seen_r;               // Delayed filtered acknowledge
    logic        irq_r;                    // Request pin, active low
    logic        irq_nxt;
    logic        ieo_r;                    // Chain enable out
    logic        ieo_nxt;
    viar_byte_t  dout_r;                   // Bus byte
    viar_byte_t  dout_nxt;
    logic        oe_r;                     // Bus drive enable
    logic        oe_nxt;
    logic        in_service_r;             // Acknowledge taken, not yet cleared
    logic        in_service_nxt;
    logic        ack_rise;                 // Acknowledge just asserted
    logic        want_irq;                 // Request allowed this cycle

    // Answer byte for the selected register
    function automatic viar_byte_t answer_byte(input viar_ans_e style, input logic sel,
                                               input viar_byte_t v1, input viar_byte_t v2);
        viar_byte_t v;
        v = sel ? v2 : v1;
        if (style == VIAR_ANS_RESTART) begin
            answer_byte = `VIAR_RST_OPCODE;
        end else begin
            answer_byte = {v[7:1], 1'b0};
        end
    endfunction

    assign ack_rise = ack_stable_r & ~ack_seen_r;
    assign want_irq = chain_mode_r & service_req & iei_stable_r & (state_r == VIAR_IDLE);

    // Next values of mode, sequence and pins
    always_comb begin
        vec_one_nxt    = vec_wr_one ? vec_wr_data : vec_one_r;
        vec_two_nxt    = vec_wr_two ? vec_wr_data : vec_two_r;
        chain_mode_nxt = chain_mode_r | set_chain_mode_cmd;
        state_nxt      = state_r;
        dout_nxt       = 8'h00;
        oe_nxt         = 1'b0;
        case (state_r)
            // Waiting for a need; acknowledge in plain mode ignored
            VIAR_IDLE: begin
                if (chain_mode_r && ack_rise && service_req && iei_stable_r) begin
                    state_nxt = VIAR_ANNOUNCED;
                end
            end
            // Next cycle is the acknowledge read
            VIAR_ANNOUNCED: begin
                state_nxt = VIAR_DRIVE;
                dout_nxt  = answer_byte(answer_style, vector_select, vec_one_r, vec_two_r);
                oe_nxt    = 1'b1;
            end
            // Hold the byte while acknowledge stays asserted
            VIAR_DRIVE: begin
                if (ack_stable_r) begin
                    dout_nxt = dout_r;
                    oe_nxt   = 1'b1;
                end else begin
                    state_nxt = VIAR_SERVICE;
                end
            end
            // In service until software clears it
            VIAR_SERVICE: begin
                if (clear_in_service_cmd) begin
                    state_nxt = VIAR_IDLE;
                end
            end
            default: begin
                state_nxt = VIAR_IDLE;
            end
        endcase
        in_service_nxt = (state_nxt != VIAR_IDLE);
        irq_nxt = ~want_irq;
        ieo_nxt = iei_stable_r & ~want_irq & (state_nxt == VIAR_IDLE) &
                  (state_r == VIAR_IDLE);
        if (!chain_mode_r) begin
            ieo_nxt = 1'b0;
        end
    end

    // Register mode, sequence and pins
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            vec_one_r    <= `VIAR_VEC1_RST;
            vec_two_r    <= `VIAR_VEC2_RST;
            chain_mode_r <= 1'b0;
            state_r      <= VIAR_IDLE;
            ack_seen_r   <= 1'b0;
            irq_r        <= 1'b1;
            ieo_r        <= 1'b0;
            dout_r       <= 8'h00;
            oe_r         <= 1'b0;
            in_service_r <= 1'b0;
        end else begin
            vec_one_r    <= vec_one_nxt;
            vec_two_r    <= vec_two_nxt;
            chain_mode_r <= chain_mode_nxt;
            state_r      <= state_nxt;
            ack_seen_r   <= ack_stable_r;
            irq_r        <= irq_nxt;
            ieo_r        <= ieo_nxt;
            dout_r       <= dout_nxt;
            oe_r         <= oe_nxt;
            in_service_r <= in_service_nxt;
        end
    end

    // Outputs straight from flip-flops
    assign irq_out_n        = irq_r;
    assign chain_enable_out = ieo_r;
    assign chain_mode       = chain_mode_r;
    assign in_service       = in_service_r;
    assign data_out         = dout_r;
    assign data_oe          = oe_r;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    AST_IRQ_NEEDS_IEI: assert property (@(posedge sys_clk) disable iff (srst)
        !irq_r |-> $past(iei_stable_r))
        else $error("request asserted while chain enable low");
    AST_IRQ_ON_NEED: assert property (@(posedge sys_clk) disable iff (srst)
        want_irq |=> !irq_r)
        else $error("request missing for service need");
    AST_IEO_LOW_WHEN_REQ: assert property (@(posedge sys_clk) disable iff (srst)
        !irq_r |-> !ieo_r)
        else $error("chain out high while requesting");
    AST_IEO_NEEDS_IEI: assert property (@(posedge sys_clk) disable iff (srst)
        ieo_r |-> $past(iei_stable_r))
        else $error("chain out high without chain in");
    AST_IEO_HOLD_SERVICE: assert property (@(posedge sys_clk) disable iff (srst)
        (state_r == VIAR_SERVICE && !clear_in_service_cmd) |=> !ieo_r)
        else $error("chain out rose before clear");
    AST_DRIVE_AFTER_ACK: assert property (@(posedge sys_clk) disable iff (srst)
        (state_r == VIAR_IDLE && state_nxt == VIAR_ANNOUNCED) |-> ##2 oe_r)
        else $error("vector not driven two cycles after acknowledge");
    AST_OE_ONLY_ACK: assert property (@(posedge sys_clk) disable iff (srst)
        oe_r |-> $past(ack_stable_r))
        else $error("bus driven outside acknowledge");
    AST_LSB_ZERO: assert property (@(posedge sys_clk) disable iff (srst)
        (oe_r && answer_style == VIAR_ANS_VECTOR && $stable(answer_style)) |-> !dout_r[0])
        else $error("vector lsb not zero");
    AST_PLAIN_AFTER_RESET: assert property (@(posedge sys_clk) disable iff (srst)
        $past(srst) |-> !chain_mode_r)
        else $error("chain mode set after reset");
    AST_VECTOR_VALUE: assert property (@(posedge sys_clk) disable iff (srst)
        (state_r == VIAR_ANNOUNCED && answer_style == VIAR_ANS_VECTOR && !vector_select)
        |=> dout_r == {$past(vec_one_r[7:1]), 1'b0})
        else $error("wrong vector byte");

    COV_REQUEST: cover property (@(posedge sys_clk) disable iff (srst) $fell(irq_r));
    COV_ACK_READ: cover property (@(posedge sys_clk) disable iff (srst) $rose(oe_r));
    COV_CLEAR: cover property (@(posedge sys_clk) disable iff (srst)
        state_r == VIAR_SERVICE && clear_in_service_cmd);
endmodule
`default_nettype wire

// >>> viar_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Host side of the request and acknowledge
// ----------------------------------------
module viar_host_model (
    input  wire logic        sys_clk,
    input  wire logic        srst,
    input  wire logic        irq_out_n,
    input  wire logic [7:0]  data_out,
    input  wire logic        data_oe,
    input  wire logic [1:0]  mode,
    input  wire logic [7:0]  page,
    output logic             host_ack_out_n,
    output logic [15:0]      handler_addr,
    output logic [7:0]       ack_count
);
    int i;  // Bounded wait counter
    logic bus_status_0_n;  // Status code, bit 0
    logic bus_status_1_n;  // Status code, bit 1
    logic bus_status_2_n;  // Status code, bit 2
    // Acknowledge strobe decoded from the all-zero status code
    assign host_ack_out_n = bus_status_0_n | bus_status_1_n | bus_status_2_n;
    // Mode 0 restart, 1 fixed address, 2 peripheral vector
    initial begin
        {bus_status_2_n, bus_status_1_n, bus_status_0_n} = 3'b111;
        handler_addr   = 16'h0000;
        ack_count      = 8'h00;
        forever begin
            @(posedge sys_clk);
            if (!srst && irq_out_n === 1'b0) begin
                repeat (3) @(posedge sys_clk); // Current instruction completes
                if (mode == 2'd1) begin
                    // No acknowledge, branch to fixed entry
                    handler_addr <= 16'h0038;
                    for (i = 0; i < 100 && irq_out_n === 1'b0; i++) @(posedge sys_clk);
                end else begin
                    {bus_status_2_n, bus_status_1_n, bus_status_0_n} <= 3'b000; // Acknowledge code
                    for (i = 0; i < 20 && data_oe !== 1'b1; i++) @(negedge sys_clk);
                    if (mode == 2'd0) begin
                        handler_addr <= {10'h000, data_out[5:3], 3'b000}; // Restart address
                    end else begin
                        handler_addr <= {page, data_out}; // Page plus vector
                    end
                    repeat (2) @(posedge sys_clk);
                    {bus_status_2_n, bus_status_1_n, bus_status_0_n} <= 3'b111; // Passive code
                    ack_count      <= ack_count + 8'h01;
                    repeat (8) @(posedge sys_clk);
                end
            end
        end
    end
endmodule
`default_nettype wire

// >>> testbench.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin failures++; \
    $display("Error t=%0t got %h exp %h", $time, a, e); end end
module testbench;
    import viar_pkg::*;
    logic        sys_clk = 1'b0, srst = 1'b1, service_req = 1'b0, vector_select = 1'b0;
    viar_ans_e   answer_style = VIAR_ANS_VECTOR;
    logic        set_chain_mode_cmd = 1'b0, clear_in_service_cmd = 1'b0;
    logic        vec_wr_one = 1'b0, vec_wr_two = 1'b0, chain_enable_in = 1'b1;
    viar_byte_t  vec_wr_data = 8'h00, data_out;
    logic        ack_in_n, irq_out_n, chain_enable_out, chain_mode, in_service, data_oe;
    logic [1:0]  hmode = 2'd2;
    logic [15:0] haddr;
    logic [7:0]  hcnt;
    int          failures = 0, comparisons = 0, i;
    // ----------------------------------------
    // Clock, device and host
    // ----------------------------------------
    always #20 sys_clk = ~sys_clk;
    viar_responder dut (.sys_clk(sys_clk), .srst(srst), .service_req(service_req),
        .vector_select(vector_select), .answer_style(answer_style),
        .set_chain_mode_cmd(set_chain_mode_cmd), .clear_in_service_cmd(clear_in_service_cmd),
        .vec_wr_one(vec_wr_one), .vec_wr_two(vec_wr_two), .vec_wr_data(vec_wr_data),
        .ack_in_n(ack_in_n), .chain_enable_in(chain_enable_in), .irq_out_n(irq_out_n),
        .chain_enable_out(chain_enable_out), .chain_mode(chain_mode),
        .in_service(in_service), .data_out(data_out), .data_oe(data_oe));
    viar_host_model host (.sys_clk(sys_clk), .srst(srst), .irq_out_n(irq_out_n),
        .data_out(data_out), .data_oe(data_oe), .mode(hmode), .page(8'h12),
        .host_ack_out_n(ack_in_n), .handler_addr(haddr), .ack_count(hcnt));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask
    task automatic stop_test();
        $display("failures=%0d comparisons=%0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    // Plain mode refuses, then gated chain mode
    task automatic t_gate();
        `CHK(chain_mode, 1'b0)
        @(posedge sys_clk) service_req <= 1'b1;
        settle(8);
        `CHK(irq_out_n, 1'b1)
        @(posedge sys_clk) chain_enable_in <= 1'b0;
        settle(6);
        @(posedge sys_clk) set_chain_mode_cmd <= 1'b1;
        @(posedge sys_clk) set_chain_mode_cmd <= 1'b0;
        settle(10);
        `CHK(chain_mode, 1'b1)
        `CHK(irq_out_n, 1'b1)
        `CHK(chain_enable_out, 1'b0)
        @(posedge sys_clk) service_req <= 1'b0;
        chain_enable_in <= 1'b1;
        settle(8);
        `CHK(chain_enable_out, 1'b1)
    endtask
    // Full request, acknowledge and clear
    task automatic t_ack(input viar_ans_e st, input logic [1:0] hm, input logic sel,
                         input logic [15:0] exp);
        logic [7:0] old;
        old = hcnt;
        @(posedge sys_clk);
        answer_style <= st;
        hmode <= hm;
        vector_select <= sel;
        service_req <= 1'b1;
        settle(3);
        `CHK(irq_out_n, 1'b0)
        `CHK(chain_enable_out, 1'b0)
        `CHK(data_oe, 1'b0)
        for (i = 0; i < 80 && hcnt == old; i++) @(negedge sys_clk);
        `CHK(haddr, exp)
        @(posedge sys_clk) service_req <= 1'b0;
        settle(8);
        `CHK(data_oe, 1'b0)
        `CHK(chain_enable_out, 1'b0)
        `CHK(in_service, 1'b1)
        @(posedge sys_clk) clear_in_service_cmd <= 1'b1;
        @(posedge sys_clk) clear_in_service_cmd <= 1'b0;
        settle(4);
        `CHK(chain_enable_out, 1'b1)
    endtask
    // Fixed-address host never acknowledges
    task automatic t_fixed();
        @(posedge sys_clk);
        hmode <= 2'd1;
        service_req <= 1'b1;
        settle(14);
        `CHK(irq_out_n, 1'b0)
        `CHK(data_oe, 1'b0)
        `CHK(haddr, 16'h0038)
        @(posedge sys_clk) service_req <= 1'b0;
        settle(4);
        `CHK(irq_out_n, 1'b1)
    endtask
    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial begin
        repeat (16) @(posedge sys_clk);
        srst <= 1'b0;
        vec_wr_data <= 8'h5b;
        vec_wr_one <= 1'b1;
        @(posedge sys_clk) vec_wr_one <= 1'b0;
        vec_wr_data <= 8'ha6;
        vec_wr_two <= 1'b1;
        @(posedge sys_clk) vec_wr_two <= 1'b0;
        settle(4);
        `CHK(irq_out_n, 1'b1)
        t_gate();
        t_ack(VIAR_ANS_VECTOR, 2'd2, 1'b0, 16'h125a);
        t_ack(VIAR_ANS_VECTOR, 2'd2, 1'b1, 16'h12a6);
        t_ack(VIAR_ANS_RESTART, 2'd0, 1'b1, 16'h0000);
        t_fixed();
        stop_test();
    end
    initial begin
        repeat (3000) @(posedge sys_clk);
        failures++;
        stop_test();
    end
endmodule
`default_nettype wire
